// [shared/mem_init_pkg.sv]
// Constants and types shared by the memory initialization controller
package mem_init_pkg;

  // Clock and timing figures
  localparam int unsigned CLK_PERIOD_PS    = 8000;
  localparam int unsigned T_RESET_PWR_US   = 200;
  localparam int unsigned T_RESET_WARM_NS  = 100;
  localparam int unsigned T_CKE_SETUP_NS   = 10;
  localparam int unsigned T_INIT_US        = 500;
  localparam int unsigned T_CLK_STABLE_NS  = 10;
  localparam int unsigned CLK_STABLE_TCK   = 5;
  localparam int unsigned XPR_MIN_TCK      = 5;

  localparam int unsigned RESET_PWR_CYC =
    (T_RESET_PWR_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RESET_WARM_CYC =
    (T_RESET_WARM_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CKE_SETUP_CYC =
    (T_CKE_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned INIT_CYC =
    (T_INIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CLK_STABLE_NS_CYC =
    (T_CLK_STABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Default wait counts that the application normally overrides
  localparam int unsigned XS_CYC_DEF    = 64;
  localparam int unsigned MRD_CYC_DEF   = 4;
  localparam int unsigned MOD_CYC_DEF   = 12;
  localparam int unsigned DLLK_CYC_DEF  = 512;
  localparam int unsigned ZQINIT_CYC_DEF = 512;

  // Bank codes of the mode registers
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;
  localparam logic [2:0] BA_MR3 = 3'h3;
  localparam int unsigned MR1_DLL_DIS_BIT = 0;
  localparam int unsigned MR0_DLL_RST_BIT = 8;
  localparam int unsigned ZQ_LONG_BIT     = 10;

  // Wishbone register map (byte addresses)
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MR01   = 4'h8;
  localparam logic [3:0] ADDR_MR23   = 4'hc;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_WARM_BIT  = 1;
  localparam int unsigned CTRL_ODT_BIT   = 2;
  localparam logic [31:0] MR01_RESET = 32'h0000_0000;
  localparam logic [31:0] MR23_RESET = 32'h0000_0000;

  // Command encoding {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_DESEL = 4'h8,
    CMD_NOP   = 4'h7,
    CMD_MRS   = 4'h0,
    CMD_ZQCL  = 4'h6
  } mem_cmd_t;

  typedef struct packed {
    logic       reset_n;
    logic       cke;
    logic       odt;
    mem_cmd_t   cmd;
    logic [2:0] ba;
    logic [12:0] addr;
  } mem_pins_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [3:0]  adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_RESET, ST_CKE_LOW, ST_INIT_WAIT, ST_CLK_WAIT, ST_XPR,
    ST_MRS, ST_MRD, ST_ZQCL, ST_CAL_WAIT, ST_READY
  } init_state_t;

endpackage

// [design/mem_init_ctrl.sv]
// Power-up and reset initialization sequencer for a DDR3 memory device
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps

module mem_init_ctrl
  import mem_init_pkg::*;
#(
  parameter int unsigned RESET_PWR_CYC_P = mem_init_pkg::RESET_PWR_CYC,
  parameter int unsigned INIT_CYC_P      = mem_init_pkg::INIT_CYC,
  parameter int unsigned XS_CYC_P        = mem_init_pkg::XS_CYC_DEF,
  parameter int unsigned MRD_CYC_P       = mem_init_pkg::MRD_CYC_DEF,
  parameter int unsigned MOD_CYC_P       = mem_init_pkg::MOD_CYC_DEF,
  parameter int unsigned DLLK_CYC_P      = mem_init_pkg::DLLK_CYC_DEF,
  parameter int unsigned ZQINIT_CYC_P    = mem_init_pkg::ZQINIT_CYC_DEF,
  parameter int unsigned CK_DIV_P        = 2
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [3:0]              wb_adr_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  output mem_init_pkg::mem_pins_t      mem_o,
  output logic                         mem_ck_o,
  output logic                         init_done_o
);
  import mem_init_pkg::*;

  localparam int unsigned CW = 20;
  localparam int unsigned CNT_LIM = 1 << CW;
  // Exit and settle waits in ref_clk cycles; one memory clock is CK_DIV_P
  localparam int unsigned XPR_CYC =
    (XS_CYC_P > XPR_MIN_TCK * CK_DIV_P) ? XS_CYC_P : XPR_MIN_TCK * CK_DIV_P;
  localparam int unsigned CLK_STB_CYC =
    (CLK_STABLE_NS_CYC > CLK_STABLE_TCK * CK_DIV_P) ?
    CLK_STABLE_NS_CYC : CLK_STABLE_TCK * CK_DIV_P;
  localparam int unsigned CAL_CYC =
    (DLLK_CYC_P > ZQINIT_CYC_P) ? DLLK_CYC_P : ZQINIT_CYC_P;
  localparam int unsigned MRS_GAP =
    (MRD_CYC_P > MOD_CYC_P) ? MRD_CYC_P : MOD_CYC_P;

  // Elaboration checks; a zero count would wrap the down-counter to its
  // top value, and a count above CNT_LIM would be cut silently
  if (CK_DIV_P < 2 || CK_DIV_P % 2 != 0) begin : g_bad_div
    $error("CK_DIV_P must be even and at least 2");
  end
  if (CK_DIV_P / 2 > 256) begin : g_bad_div_len
    $error("CK_DIV_P too large for the eight-bit divider");
  end
  if (RESET_PWR_CYC_P < 1 || RESET_PWR_CYC_P >= CNT_LIM) begin : g_bad_rst
    $error("RESET_PWR_CYC_P out of range");
  end
  if (RESET_WARM_CYC < 1 || RESET_WARM_CYC >= CNT_LIM) begin : g_bad_warm
    $error("Warm reset count out of range");
  end
  if (INIT_CYC_P < 1 || INIT_CYC_P >= CNT_LIM) begin : g_bad_init
    $error("INIT_CYC_P out of range");
  end
  if (XS_CYC_P < 1 || XPR_CYC >= CNT_LIM) begin : g_bad_xpr
    $error("XS_CYC_P out of range");
  end
  if (CLK_STB_CYC >= CNT_LIM) begin : g_bad_clk
    $error("Clock settle count out of range");
  end
  if (MRD_CYC_P < 1 || MRD_CYC_P >= CNT_LIM) begin : g_bad_mrd
    $error("MRD_CYC_P out of range");
  end
  if (MOD_CYC_P < 1 || MOD_CYC_P >= CNT_LIM) begin : g_bad_mod
    $error("MOD_CYC_P out of range");
  end
  if (DLLK_CYC_P < 1 || ZQINIT_CYC_P < 1) begin : g_bad_cal_zero
    $error("DLLK_CYC_P and ZQINIT_CYC_P must be at least 1");
  end
  if (CAL_CYC >= CNT_LIM) begin : g_bad_cal
    $error("Calibration wait out of range");
  end
  if (MRS_GAP >= CNT_LIM) begin : g_bad_gap
    $error("Mode write gap out of range");
  end

  function automatic logic [CW-1:0] cnt_of(input int unsigned n);
    cnt_of = CW'(n - 1);
  endfunction

  init_state_t        state_r;
  logic [CW-1:0]      cnt_r;
  logic [1:0]         mr_idx_r;
  logic [31:0]        mr01_r;
  logic [31:0]        mr23_r;
  logic               odt_r;
  logic               warm_r;
  logic               busy_err_r;
  logic [7:0]         ck_div_r;
  logic               ck_run_r;
  logic               wb_hit;
  logic               wb_wr;

  // A request is taken while ack is low and answered one cycle later; a
  // write lands on the edge at which the master sees ack high
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  // Output clock divider; runs only once the sequencer enables it
  // Stopped low, so no partial clock pulse reaches the device on restart
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ck_div_r <= 8'h00;
      mem_ck_o <= 1'b0;
    end else if (!ck_run_r) begin
      ck_div_r <= 8'h00;
      mem_ck_o <= 1'b0;
    end else if (ck_div_r == 8'(CK_DIV_P / 2 - 1)) begin
      ck_div_r <= 8'h00;
      mem_ck_o <= ~mem_ck_o;
    end else begin
      ck_div_r <= ck_div_r + 8'h01;
    end
  end

  // Wishbone slave: one registered answer per request, one cycle late
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          ADDR_CTRL:   wb_dat_o <= {29'h0, odt_r, warm_r, 1'b0};
          ADDR_STATUS: wb_dat_o <= {25'h0, busy_err_r, 4'(state_r),
                                    (state_r != ST_IDLE &&
                                     state_r != ST_READY),
                                    init_done_o};
          ADDR_MR01:   wb_dat_o <= mr01_r;
          ADDR_MR23:   wb_dat_o <= mr23_r;
          default:     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register map: 0 control (start, warm reset, odt level), 4 status
  // {busy_err, state, busy, done}, 8 MR0 low half and MR1 high half,
  // c MR2 low half and MR3 high half.
  // Mode register images and options; frozen while a sequence runs, so
  // every mode write carries a full and settled image
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mr01_r     <= MR01_RESET;
      mr23_r     <= MR23_RESET;
      odt_r      <= 1'b0;
      warm_r     <= 1'b0;
      busy_err_r <= 1'b0;
    end else if (wb_wr) begin
      if (state_r != ST_IDLE && state_r != ST_READY) begin
        busy_err_r <= 1'b1;
      end else begin
        unique case (wb_adr_i)
          ADDR_CTRL: begin
            odt_r  <= wb_sel_i[0] ? wb_dat_i[CTRL_ODT_BIT] : odt_r;
            warm_r <= wb_sel_i[0] ? wb_dat_i[CTRL_WARM_BIT] : warm_r;
            if (wb_sel_i[0] && wb_dat_i[CTRL_START_BIT])
              busy_err_r <= 1'b0;
          end
          ADDR_MR01: begin
            for (int b = 0; b < 4; b++)
              if (wb_sel_i[b]) mr01_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
          ADDR_MR23: begin
            for (int b = 0; b < 4; b++)
              if (wb_sel_i[b]) mr23_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
          default: ;
        endcase
      end
    end
  end

  // Software must only start from READY while the device is idle; the
  // block cannot see bank state, so it only refuses a running sequence
  logic start_req;
  assign start_req = wb_wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0] &&
                     wb_dat_i[CTRL_START_BIT] &&
                     (state_r == ST_IDLE || state_r == ST_READY);

  // MRS address word, full field image each time
  function automatic logic [12:0] mr_word(input logic [1:0] idx);
    unique case (idx)
      2'd0: mr_word = mr23_r[12:0];
      2'd1: mr_word = mr23_r[28:16];
      2'd2: begin
        mr_word = mr01_r[28:16];
        mr_word[MR1_DLL_DIS_BIT] = 1'b0;
      end
      default: begin
        mr_word = mr01_r[12:0];
        mr_word[MR0_DLL_RST_BIT] = 1'b1;
      end
    endcase
  endfunction

  function automatic logic [2:0] mr_bank(input logic [1:0] idx);
    unique case (idx)
      2'd0:    mr_bank = BA_MR2;
      2'd1:    mr_bank = BA_MR3;
      2'd2:    mr_bank = BA_MR1;
      default: mr_bank = BA_MR0;
    endcase
  endfunction

  // Flow: reset_n and cke low, reset wait, reset_n high, quiet wait with
  // the clock stopped, clock on and odt set, clock settle, cke high, exit
  // wait, four mode writes spaced by the write gap (the last by the longer
  // update gap), long calibration, then the lock and calibration wait.
  // Limitation: a command stands one ref_clk cycle, half a memory clock at the default CK_DIV_P of 2,
  // so the pin stage must retime it onto the memory clock rise.
  // Initialization sequencer; every wait is a cycle count
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r     <= ST_IDLE;
      cnt_r       <= '0;
      mr_idx_r    <= 2'd0;
      ck_run_r    <= 1'b0;
      init_done_o <= 1'b0;
      mem_o.reset_n <= 1'b0;
      mem_o.cke   <= 1'b0;
      mem_o.odt   <= 1'b0;
      mem_o.cmd   <= CMD_DESEL;
      mem_o.ba    <= 3'h0;
      mem_o.addr  <= 13'h0000;
    end else begin
      mem_o.cmd  <= CMD_NOP;
      mem_o.ba   <= 3'h0;
      mem_o.addr <= 13'h0000;
      unique case (state_r)
        ST_IDLE, ST_READY: begin
          if (start_req) begin
            init_done_o   <= 1'b0;
            mem_o.reset_n <= 1'b0;
            mem_o.cke     <= 1'b0;
            ck_run_r      <= 1'b0;
            // The warm bit comes from this START write, not the old copy
            cnt_r <= wb_dat_i[CTRL_WARM_BIT]
                     ? cnt_of(RESET_WARM_CYC)
                     : cnt_of(RESET_PWR_CYC_P);
            state_r <= ST_RESET;
          end
        end
        ST_RESET: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          // cke fell with reset_n; only a reset shorter than the cke
          // setup time needs the extra low stretch before release
          end else if (CKE_SETUP_CYC > RESET_WARM_CYC) begin
            cnt_r   <= cnt_of(CKE_SETUP_CYC);
            state_r <= ST_CKE_LOW;
          end else begin
            mem_o.reset_n <= 1'b1;
            cnt_r   <= cnt_of(INIT_CYC_P);
            state_r <= ST_INIT_WAIT;
          end
        end
        ST_CKE_LOW: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            mem_o.reset_n <= 1'b1;
            cnt_r   <= cnt_of(INIT_CYC_P);
            state_r <= ST_INIT_WAIT;
          end
        end
        ST_INIT_WAIT: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            ck_run_r <= 1'b1;
            mem_o.odt <= odt_r;
            cnt_r   <= cnt_of(CLK_STB_CYC);
            state_r <= ST_CLK_WAIT;
          end
        end
        ST_CLK_WAIT: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            mem_o.cke <= 1'b1;
            cnt_r   <= cnt_of(XPR_CYC);
            state_r <= ST_XPR;
          end
        end
        ST_XPR: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            mr_idx_r <= 2'd0;
            state_r  <= ST_MRS;
          end
        end
        // Only MRS, ZQCL and NOP/DESEL fillers leave this block; column commands with their
        // auto precharge and chop bits belong to the main controller
        ST_MRS: begin
          mem_o.cmd  <= CMD_MRS;
          mem_o.ba   <= mr_bank(mr_idx_r);
          mem_o.addr <= mr_word(mr_idx_r);
          cnt_r   <= (mr_idx_r == 2'd3) ? cnt_of(MOD_CYC_P)
                                        : cnt_of(MRD_CYC_P);
          state_r <= ST_MRD;
        end
        ST_MRD: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (mr_idx_r == 2'd3) begin
            state_r <= ST_ZQCL;
          end else begin
            mr_idx_r <= mr_idx_r + 2'd1;
            state_r  <= ST_MRS;
          end
        end
        ST_ZQCL: begin
          mem_o.cmd  <= CMD_ZQCL;
          mem_o.addr <= 13'(1 << ZQ_LONG_BIT);
          cnt_r   <= cnt_of(CAL_CYC);
          state_r <= ST_CAL_WAIT;
        end
        ST_CAL_WAIT: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            init_done_o <= 1'b1;
            state_r     <= ST_READY;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // mem_init_ctrl

// [test/ddr3_dev_model.sv]
// Behavioural memory device that records mode register writes
`timescale 1ns/1ps
module ddr3_dev_model
  import mem_init_pkg::*;
(
  input  wire logic                     ref_clk_i,
  input  wire mem_init_pkg::mem_pins_t  mem_i,
  output logic [12:0]                   mr_o [4],
  output logic                          term_on_o,
  output logic [3:0]                    zq_cnt_o
);
  wire rst_n = mem_i.reset_n;
  // Commands last half a memory clock, so they are taken on ref_clk
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mr_o      <= '{default: 'x};
      term_on_o <= 1'b0;
      zq_cnt_o  <= 4'h0;
    end else begin
      term_on_o <= mem_i.cke & mem_i.odt;
      // No array is held, so mode writes cannot disturb it
      // Row opens and bursts are not modelled; bank bits pick the MR
      // Data bursts of eight or four beats are outside this model
      if (mem_i.cke && mem_i.cmd == CMD_MRS) begin
        mr_o[mem_i.ba[1:0]] <= mem_i.addr;
      end
      if (mem_i.cke && mem_i.cmd == CMD_ZQCL) begin
        zq_cnt_o <= zq_cnt_o + 4'h1;
      end
    end
  end
endmodule // ddr3_dev_model

// [test/mem_init_monitor.sv]
// Checker of the initialization sequence at the controller's ports
`timescale 1ns/1ps
module mem_init_monitor
  import mem_init_pkg::*;
#(
  parameter int unsigned INIT_CYC_P   = 30,
  parameter int unsigned XS_CYC_P     = 8,
  parameter int unsigned MRD_CYC_P    = 4,
  parameter int unsigned MOD_CYC_P    = 12,
  parameter int unsigned DLLK_CYC_P   = 16,
  parameter int unsigned ZQINIT_CYC_P = 16
) (
  input wire logic                     ref_clk_i,
  input wire logic                     rst_i,
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_ack_o,
  input wire mem_init_pkg::mem_pins_t  mem_o,
  input wire logic                     mem_ck_o,
  input wire logic                     init_done_o
);
  localparam logic [2:0] ORD [4] = '{BA_MR2, BA_MR3, BA_MR1, BA_MR0};
  logic [15:0] rn_hi, cke_hi, ck_tg, gap, zq_age;
  logic [2:0]  idx;
  logic        ck_q, init_f;
  wire mrs = mem_o.cmd == CMD_MRS;
  wire zq  = mem_o.cmd == CMD_ZQCL;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Saturating ages keep the long waits measurable with short counters
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {rn_hi, cke_hi, ck_tg, gap, zq_age, idx, ck_q, init_f} <= '0;
    end else begin
      ck_q   <= mem_ck_o;
      rn_hi  <= mem_o.reset_n ? rn_hi + {15'h0, ~&rn_hi} : '0;
      cke_hi <= mem_o.cke ? cke_hi + {15'h0, ~&cke_hi} : '0;
      ck_tg  <= !mem_o.reset_n ? '0
              : ck_tg + {15'h0, (mem_ck_o != ck_q) && ~&ck_tg};
      gap    <= mrs ? '0 : gap + {15'h0, ~&gap};
      zq_age <= zq ? '0 : zq_age + {15'h0, ~&zq_age};
      idx    <= (!mem_o.reset_n || zq) ? 3'h0 : idx + {2'h0, mrs};
      // Only a fresh rise of cke opens the window, not cke still held high after done
      init_f <= (init_f || (mem_o.cke && cke_hi == 0)) && !init_done_o;
    end
  end
  a_cke_low_first:
    assert property ($rose(mem_o.reset_n) |->
      !$past(mem_o.cke) && !$past(mem_o.cke, 2))
    else $error("cke not low before reset release");
  a_init_wait:
    assert property ($rose(mem_o.cke) |-> rn_hi >= INIT_CYC_P)
    else $error("cke raised too soon after reset release");
  a_clk_and_nop:
    assert property ($rose(mem_o.cke) |-> ck_tg >= 9 &&
      $past(mem_o.cmd) inside {CMD_NOP, CMD_DESEL})
    else $error("clock or nop missing before cke rise");
  a_cke_odt_held:
    assert property (init_f && !init_done_o |=>
      mem_o.cke && $stable(mem_o.odt))
    else $error("cke or odt moved during initialization");
  a_xpr_wait:
    assert property (mrs && idx == 0 |-> cke_hi >= XS_CYC_P && cke_hi >= 10)
    else $error("first mode write too soon after cke");
  a_mrs_order:
    assert property (mrs |-> idx < 4 && mem_o.ba == ORD[idx[1:0]])
    else $error("mode register order wrong");
  a_dll_bits:
    assert property (mrs |-> (mem_o.ba != BA_MR1 || !mem_o.addr[0]) &&
      (mem_o.ba != BA_MR0 || mem_o.addr[8]))
    else $error("dll enable or dll reset bit wrong");
  a_mrd_gap:
    assert property (mrs && idx != 0 |-> gap >= MRD_CYC_P - 1)
    else $error("mode writes too close");
  a_zq_long:
    assert property (zq |-> idx == 4 && mem_o.addr[ZQ_LONG_BIT] &&
      gap >= MOD_CYC_P - 1)
    else $error("calibration command misplaced");
  a_gap_nop:
    assert property (idx != 0 && !mrs && !zq |->
      mem_o.cmd inside {CMD_NOP, CMD_DESEL})
    else $error("other command inside mode write window");
  a_cal_wait:
    assert property ($rose(init_done_o) |-> zq_age >= DLLK_CYC_P - 1 &&
      zq_age >= ZQINIT_CYC_P - 1)
    else $error("done raised before calibration wait");
  a_wb_ack:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
      wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle pulse");
  c_done: cover property ($rose(init_done_o));
  c_mr0: cover property (mrs && mem_o.ba == BA_MR0);
  c_zq: cover property (zq);
endmodule // mem_init_monitor
bind mem_init_ctrl mem_init_monitor #(.INIT_CYC_P(INIT_CYC_P),
  .XS_CYC_P(XS_CYC_P), .MRD_CYC_P(MRD_CYC_P), .MOD_CYC_P(MOD_CYC_P),
  .DLLK_CYC_P(DLLK_CYC_P), .ZQINIT_CYC_P(ZQINIT_CYC_P))
  mem_init_monitor_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .mem_o(mem_o), .mem_ck_o(mem_ck_o), .init_done_o(init_done_o));

// [test/mem_init_ctrl_tb.sv]
// Self-checking bench for the memory initialization controller
`timescale 1ns/1ps
module mem_init_ctrl_tb;
  import mem_init_pkg::*;
  logic        ref_clk_i, rst_i, cyc, stb, we, wb_ack_o, mem_ck_o;
  logic        init_done_o, term_on;
  logic [3:0]  adr, zq_cnt, sel;
  logic [31:0] dat, wb_dat_o, q;
  logic [12:0] mr [4];
  mem_pins_t   mem_o;
  int          err_total, n_tests, cycles, rn_low, rn_last;

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  mem_init_ctrl #(.RESET_PWR_CYC_P(20), .INIT_CYC_P(30), .XS_CYC_P(8),
    .DLLK_CYC_P(16), .ZQINIT_CYC_P(16)) mem_init_ctrl_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_o(mem_o),
    .mem_ck_o(mem_ck_o), .init_done_o(init_done_o));
  ddr3_dev_model ddr3_dev_model_inst (.ref_clk_i(ref_clk_i), .mem_i(mem_o),
    .mr_o(mr), .term_on_o(term_on), .zq_cnt_o(zq_cnt));

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Length of the last low stretch of the memory reset pin, counted from
  // the acknowledged START write so the idle time before it is left out
  wire start_ack = cyc && stb && we && wb_ack_o && adr == ADDR_CTRL && dat[0];
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    rn_low <= (mem_o.reset_n || start_ack) ? 0 : rn_low + 1;
    if (mem_o.reset_n === 1'b1 && rn_low > 0) rn_last <= rn_low;
    if (cycles > 4000) begin
      err_total++;
      $display("BAD timeout expected done seen hang");
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk_i);
    chk("ack", 1, n < 20);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  task automatic wait_done();
    for (int n = 0; n < 400 && init_done_o !== 1'b1; n++) begin
      @(posedge ref_clk_i);
    end
    chk("done", 1, init_done_o);
  endtask

  initial begin
    {cyc, stb, we, adr, dat} = '0;
    sel = 4'hf;
    {err_total, n_tests, cycles, rn_low, rn_last} = '0;
    rst_i = 1'b1;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(ADDR_MR01, MR01_RESET, "mr01 reset");
    rd(4'h2, 32'h0, "unmapped");
    wb(1'b1, ADDR_MR01, 32'h1235_0000);
    // Low two lanes only: the high half must keep its earlier value
    sel <= 4'h3;
    wb(1'b1, ADDR_MR01, 32'hffff_0a31);
    sel <= 4'hf;
    wb(1'b1, ADDR_MR23, 32'h0018_0207);
    rd(ADDR_MR01, 32'h1235_0a31, "mr01");
    wb(1'b1, ADDR_CTRL, 32'h5);
    // Writes during a running sequence must be dropped and flagged
    wb(1'b1, ADDR_MR23, 32'h0);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk("busy flags", 2'b11, {q[6], q[1]});
    wait_done();
    rd(ADDR_MR23, 32'h0018_0207, "mr23 kept");
    chk("reset low", 1, rn_last >= 20);
    chk("mr2", 13'h0207, mr[2]);
    chk("mr3", 13'h0018, mr[3]);
    chk("mr1", 13'h1234, mr[1]);
    chk("mr0", 13'h0b31, mr[0]);
    chk("zq", 1, zq_cnt);
    chk("term", 1, term_on);
    // Warm restart from ready with a new MR2 and ODT held low
    wb(1'b1, ADDR_MR23, 32'h0018_0010);
    wb(1'b1, ADDR_CTRL, 32'h3);
    repeat (2) @(posedge ref_clk_i);
    chk("done drop", 0, init_done_o);
    chk("term off", 0, term_on);
    wait_done();
    chk("warm low", 1, rn_last >= 13 && rn_last < 20);
    chk("mr2 new", 13'h0010, mr[2]);
    chk("mr1 new", 13'h1234, mr[1]);
    chk("term warm", 0, term_on);
    chk("zq warm", 1, zq_cnt);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk("status done", 2'b01, q[1:0]);
    results();
  end
endmodule // mem_init_ctrl_tb
